// >>> pkg/tos_pkg.sv
// Constants and types for the touch output stage
package tos_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned PULSE_MS      = 75;
  localparam int unsigned TONE_MS       = 95;
  localparam int unsigned FLOAT_US      = 350;
  localparam int unsigned TONE_HZ       = 4000;
  localparam int unsigned TIMEOUT_S_SHORT = 10;
  localparam int unsigned TIMEOUT_S_LONG  = 60;
  localparam int unsigned CONFIRM_COUNT = 4;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned FLOAT_CYC     = FLOAT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HALF_TONE_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam logic [1:0] STRAP_LEVEL10 = 2'h3;
  localparam logic [1:0] STRAP_LEVEL60 = 2'h2;
  localparam logic [1:0] STRAP_TOGGLE  = 2'h0;
  localparam logic [1:0] STRAP_PULSE   = 2'h1;

  typedef enum logic [1:0] {
    TOS_LEVEL  = 2'b00,
    TOS_TOGGLE = 2'b01,
    TOS_PULSE  = 2'b10
  } tos_mode_t;
endpackage

// >>> pkg/tos_tick_if.sv
// Millisecond tick carrier between the stage and its divider
`timescale 1ns/1ps
interface tos_tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input  ms_tick);
endinterface

// >>> core/tos_ms_div.sv
// Divider making a one-cycle millisecond enable
`timescale 1ns/1ps
module tos_ms_div
  import tos_pkg::*;
#(
  // Cycles per tick; a bench may shorten it to reach the long timers
  parameter int unsigned TICK_CYC_P = MS_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Tick out
  tos_tick_if.src   tick
);
  typedef struct packed {
    logic [16:0] cnt;
    logic        tick;
  } tos_div_t;
  tos_div_t st_reg;
  tos_div_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 17'(TICK_CYC_P - 1)) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 17'h0_001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick.ms_tick = st_reg.tick;
endmodule // tos_ms_div

// >>> core/tos_output_stage.sv
// Touch sensor output stage: modes, pulse, tone and health float
`timescale 1ns/1ps
module tos_output_stage
  import tos_pkg::*;
#(
  parameter int unsigned PULSE_MS_P = PULSE_MS,
  parameter int unsigned TONE_MS_P  = TONE_MS,
  parameter int unsigned SHORT_S_P  = TIMEOUT_S_SHORT,
  parameter int unsigned LONG_S_P   = TIMEOUT_S_LONG,
  parameter int unsigned TICK_CYC_P = MS_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Option straps
  input  wire logic option_strap_first_in,
  input  wire logic option_strap_second_in,
  // Acquisition results
  input  wire logic burst_start_in,
  input  wire logic burst_over_in,
  // Output pin, driven while enable is high
  output logic      out_pin_out,
  output logic      out_pin_oe_out,
  // Sense pins during tone
  output logic      sense_pin_a_out,
  output logic      sense_pin_b_out,
  output logic      sense_pins_oe_out,
  // Status
  output logic      detect_out,
  output logic      recal_req_out
);
  // ****************************************
  // Millisecond divider
  // ****************************************
  tos_tick_if tk ();

  tos_ms_div #(.TICK_CYC_P(TICK_CYC_P)) u_div (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tick   (tk.src)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        strapped;
    tos_mode_t   mode;
    logic        long_to;
    logic [2:0]  confirm;
    logic        detect;
    logic        toggled;
    logic [16:0] on_ms;
    logic [6:0]  pulse_ms;
    logic        pulse_on;
    logic [6:0]  tone_ms;
    logic        tone_on;
    logic [13:0] tone_div;
    logic        tone_ph;
    logic [15:0] float_cnt;
    logic        floating;
    logic        pin;
    logic        oe;
    logic        snd_a;
    logic        snd_b;
    logic        recal;
  } tos_state_t;

  tos_state_t st_reg;
  tos_state_t st_next;
  logic [16:0] timeout_ms;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next       = st_reg;
    st_next.recal = 1'b0;
    timeout_ms    = st_reg.long_to ? 17'(LONG_S_P * 1000) : 17'(SHORT_S_P * 1000);
    // Straps caught once, on the first clock after reset release
    if (!st_reg.strapped) begin
      st_next.strapped = 1'b1;
      unique case ({option_strap_first_in, option_strap_second_in})
        STRAP_LEVEL10: st_next.mode = TOS_LEVEL;
        STRAP_LEVEL60: begin
          st_next.mode    = TOS_LEVEL;
          st_next.long_to = 1'b1;
        end
        STRAP_TOGGLE:  st_next.mode = TOS_TOGGLE;
        STRAP_PULSE:   st_next.mode = TOS_PULSE;
      endcase
    end
    // Consensus filter on burst results
    if (burst_start_in) begin
      st_next.floating  = 1'b1;
      st_next.float_cnt = 16'(FLOAT_CYC - 1);
    end
    if (burst_over_in && !st_reg.detect) begin
      if (st_reg.confirm == 3'(CONFIRM_COUNT - 1)) begin
        st_next.confirm = '0;
        st_next.detect  = 1'b1;
        st_next.on_ms   = '0;
        st_next.toggled = ~st_reg.toggled;
        if (st_reg.mode == TOS_PULSE) begin
          st_next.pulse_on = 1'b1;
          st_next.pulse_ms = '0;
        end else begin
          st_next.tone_on  = 1'b1;
          st_next.tone_ms  = '0;
          st_next.tone_div = '0;
        end
      end else begin
        st_next.confirm = st_reg.confirm + 3'h1;
      end
    end
    // A finished burst below threshold ends detection or clears the count
    if (burst_start_in && !burst_over_in) begin
      st_next.confirm = '0;
      st_next.detect  = 1'b0;
    end
    if (tk.ms_tick) begin
      if (st_reg.detect) begin
        if (st_reg.on_ms == timeout_ms - 17'h0_001) begin
          st_next.detect = 1'b0;
          st_next.recal  = 1'b1;
        end else begin
          st_next.on_ms = st_reg.on_ms + 17'h0_001;
        end
      end
      if (st_reg.pulse_on) begin
        if (st_reg.pulse_ms == 7'(PULSE_MS_P - 1)) begin
          st_next.pulse_on = 1'b0;
        end
        st_next.pulse_ms = st_reg.pulse_ms + 7'h01;
      end
      if (st_reg.tone_on) begin
        if (st_reg.tone_ms == 7'(TONE_MS_P - 1)) begin
          st_next.tone_on = 1'b0;
        end
        st_next.tone_ms = st_reg.tone_ms + 7'h01;
      end
    end
    if (st_reg.tone_on) begin
      if (st_reg.tone_div == 14'(HALF_TONE_CYC - 1)) begin
        st_next.tone_div = '0;
        st_next.tone_ph  = ~st_reg.tone_ph;
      end else begin
        st_next.tone_div = st_reg.tone_div + 14'h0_001;
      end
    end
    if (st_reg.floating && !burst_start_in) begin
      if (st_reg.float_cnt == '0) begin
        st_next.floating = 1'b0;
      end else begin
        st_next.float_cnt = st_reg.float_cnt - 16'h0_001;
      end
    end
    // Active-low level per mode; toggle state survives a timeout
    unique case (st_reg.mode)
      TOS_LEVEL:  st_next.pin = ~st_next.detect;
      TOS_TOGGLE: st_next.pin = ~st_next.toggled;
      TOS_PULSE:  st_next.pin = ~st_next.pulse_on;
      default:    st_next.pin = 1'b1;
    endcase
    // Registered copies, so that every pin leaves a flip-flop
    st_next.oe    = ~st_next.floating;
    st_next.snd_a = st_next.tone_on & st_next.tone_ph;
    st_next.snd_b = st_next.tone_on & ~st_next.tone_ph;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg     <= '0;
      st_reg.pin <= 1'b1;
      st_reg.oe  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Float overrides whatever level is driven, in all modes
  assign out_pin_out       = st_reg.pin;
  assign out_pin_oe_out    = st_reg.oe;
  assign sense_pin_a_out   = st_reg.snd_a;
  assign sense_pin_b_out   = st_reg.snd_b;
  assign sense_pins_oe_out = st_reg.tone_on;
  assign detect_out        = st_reg.detect;
  assign recal_req_out     = st_reg.recal;

  // ****************************************
  // Assertions
  // ****************************************
  property p_float_len;
    @(posedge clk_in) disable iff (rst_in)
      $rose(st_reg.floating) && !burst_start_in |-> st_reg.floating[*8];
  endproperty
  a_float_len: assert property (p_float_len) else $error("Float ended early");

  property p_pulse_no_tone;
    @(posedge clk_in) disable iff (rst_in)
      st_reg.mode == TOS_PULSE && st_reg.strapped |-> !sense_pins_oe_out;
  endproperty
  a_pulse_no_tone: assert property (p_pulse_no_tone) else $error("Tone in pulse mode");

  property p_level_low;
    @(posedge clk_in) disable iff (rst_in)
      st_reg.mode == TOS_LEVEL && st_reg.detect |-> !out_pin_out;
  endproperty
  a_level_low: assert property (p_level_low) else $error("Level not low");

  property p_tone_opposite;
    @(posedge clk_in) disable iff (rst_in)
      sense_pins_oe_out |-> sense_pin_a_out != sense_pin_b_out;
  endproperty
  a_tone_opposite: assert property (p_tone_opposite) else $error("Tone not opposite");

  property p_float_start;
    @(posedge clk_in) disable iff (rst_in)
      burst_start_in |=> !out_pin_oe_out;
  endproperty
  a_float_start: assert property (p_float_start) else $error("No float at burst");

  property p_confirm;
    @(posedge clk_in) disable iff (rst_in)
      $rose(detect_out) |-> $past(burst_over_in);
  endproperty
  a_confirm: assert property (p_confirm) else $error("Detect without burst");

  property p_tone_start;
    @(posedge clk_in) disable iff (rst_in)
      $rose(detect_out) && st_reg.mode != TOS_PULSE |-> sense_pins_oe_out;
  endproperty
  a_tone_start: assert property (p_tone_start) else $error("No tone on detect");
endmodule // tos_output_stage

// >>> tb/tos_load_model.sv
// Load on the output pin: host input with a pull-down resistor
`timescale 1ns/1ps
module tos_load_model (
  // Pin from the stage
  input  wire logic pin_in,
  input  wire logic oe_in,
  // Level seen by the host
  output logic      line_out
);
  // Pull-down makes the float interval visible while idle
  assign line_out = oe_in ? pin_in : 1'b0;
endmodule // tos_load_model

// >>> tb/touch_output_stage_test.sv
// Self-checking bench for the touch output stage
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module touch_output_stage_test;
  import tos_pkg::*;
  logic clk_in, rst_in, s1, s2, bs, bo;
  logic pin, oe, sa, sb, soe, det, recal, line;
  int   mismatches, n_tests, n;
  // Shortened tick so that the timeouts fit in the run; pulse and tone times in ticks, timeouts in cycles
  localparam int unsigned TICK     = 10;
  localparam int unsigned PULSE_T  = 2;
  localparam int unsigned TONE_T   = 3;
  localparam int unsigned TO_SHORT = 1000 * 1 * TICK;
  localparam int unsigned TO_LONG  = 1000 * 2 * TICK;
  tos_output_stage #(
    .PULSE_MS_P(PULSE_T), .TONE_MS_P(TONE_T), .SHORT_S_P(1), .LONG_S_P(2), .TICK_CYC_P(TICK)
  ) uut (
    .clk_in(clk_in), .rst_in(rst_in),
    .option_strap_first_in(s1), .option_strap_second_in(s2),
    .burst_start_in(bs), .burst_over_in(bo),
    .out_pin_out(pin), .out_pin_oe_out(oe),
    .sense_pin_a_out(sa), .sense_pin_b_out(sb), .sense_pins_oe_out(soe),
    .detect_out(det), .recal_req_out(recal));
  tos_load_model load (.pin_in(pin), .oe_in(oe), .line_out(line));
  // ****************************************
  // Clock, reset and bus tasks
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic do_reset(input logic f, input logic s);
    rst_in = 1'b1;
    s1 = f;
    s2 = s;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    // Flipped straps after the first edge must not change the mode
    s1 = ~f;
    s2 = ~s;
  endtask
  task automatic burst(input logic over);
    bs = 1'b1;
    bo = over;
    @(negedge clk_in);
    bs = 1'b0;
    bo = 1'b0;
    // One idle cycle keeps consecutive bursts apart
    @(negedge clk_in);
  endtask
  task automatic detect_now();
    repeat (4) burst(1'b1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_level();
    do_reset(1'b1, 1'b1);
    // Idle float: the pull-down shows the release while the pin idles high
    burst(1'b0);
    `CHK(line, 1'b0)
    n = 0;
    while (oe === 1'b0 && n < 40000) begin
      n++;
      @(negedge clk_in);
    end
    // The loop starts one cycle into the float
    `CHK(n, FLOAT_CYC - 1)
    `CHK(line, 1'b1)
    repeat (3) burst(1'b1);
    burst(1'b0);
    repeat (3) burst(1'b1);
    `CHK(det, 1'b0)
    burst(1'b1);
    `CHK(det, 1'b1)
    `CHK(pin, 1'b0)
    `CHK(oe, 1'b0)
    `CHK(soe, 1'b1)
    `CHK(sa, ~sb)
    repeat ((TONE_T - 1) * TICK - 2) @(negedge clk_in);
    `CHK(soe, 1'b1)
    `CHK(pin, 1'b0)
    repeat (TICK + 2) @(negedge clk_in);
    `CHK(soe, 1'b0)
    `CHK(pin, 1'b0)
    burst(1'b0);
    `CHK(det, 1'b0)
    `CHK(pin, 1'b1)
  endtask
  task automatic t_pulse();
    do_reset(1'b0, 1'b1);
    detect_now();
    `CHK(pin, 1'b0)
    `CHK(soe, 1'b0)
    repeat ((PULSE_T - 1) * TICK - 2) @(negedge clk_in);
    `CHK(pin, 1'b0)
    repeat (TICK + 2) @(negedge clk_in);
    // Detection still stands, yet the pulse is over and no tone sounds
    `CHK(det, 1'b1)
    `CHK(pin, 1'b1)
    `CHK(soe, 1'b0)
    `CHK(oe, 1'b0)
    n = 0;
    while (recal !== 1'b1 && n < 12000) begin
      n++;
      @(negedge clk_in);
    end
    // Cycles since the detecting edge
    n = n + PULSE_T * TICK + 1;
    `CHK(recal, 1'b1)
    `CHK(n > TO_SHORT - TICK && n <= TO_SHORT, 1'b1)
    @(negedge clk_in);
    `CHK(det, 1'b0)
    `CHK(pin, 1'b1)
  endtask
  task automatic t_level60();
    do_reset(1'b1, 1'b0);
    detect_now();
    `CHK(pin, 1'b0)
    n = 0;
    while (recal !== 1'b1 && n < 25000) begin
      n++;
      @(negedge clk_in);
    end
    n = n + 1;
    `CHK(recal, 1'b1)
    `CHK(n > TO_LONG - TICK && n <= TO_LONG, 1'b1)
    @(negedge clk_in);
    `CHK(det, 1'b0)
    `CHK(pin, 1'b1)
  endtask
  task automatic t_toggle();
    do_reset(1'b0, 1'b0);
    detect_now();
    `CHK(pin, 1'b0)
    `CHK(soe, 1'b1)
    burst(1'b0);
    @(negedge clk_in);
    `CHK(det, 1'b0)
    `CHK(pin, 1'b0)
    detect_now();
    `CHK(pin, 1'b1)
    `CHK(soe, 1'b1)
  endtask
  // ****************************************
  // Sequence, watchdog and verdict
  // ****************************************
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    bs = 1'b0;
    bo = 1'b0;
    mismatches = 0;
    n_tests = 0;
    t_level();
    t_pulse();
    t_level60();
    t_toggle();
    final_report();
  end
  // Whole run needs about 65k cycles; give up at 80k
  initial begin
    #800_000;
    mismatches++;
    final_report();
  end
endmodule // touch_output_stage_test
